/* File: rtl/logic_op_decode_flags.sv */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - No-operation changes nothing but the program counter; flags stay put.
// - No-operation retires only once all outstanding bus cycles have finished.
// - Complement writes ones complement of destination at byte, word or long size.
// - Complement sets N from sign, Z on zero, clears V and C, keeps X.
// - Complement and negate-with-extend destinations accept data-alterable modes only.
// - Complement decodes bits 15..8 as 01000110, size 7..6, locator 5..0.
// - Disjunction ORs source into destination at sized width; address registers refused.
// - Disjunction decodes top 1000, data register 11..9, direction field 8..6.
// - Disjunction sets N from msb, Z on zero, clears V and C, keeps X.
// - Disjunction source locator takes any data mode; address register refused.
// - Disjunction destination locator takes memory-alterable modes only.
// - Negate-with-extend computes zero minus destination minus X, sized.
module logic_op_decode_flags (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // Register bus
   input  wire logic_op_pkg::apb_req_t  apb_req,
   output logic_op_pkg::apb_rsp_t       apb_rsp,
   // Core side
   input  wire logic                    bus_pending,
   output logic_op_pkg::core_evt_t      core_evt
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic_op_pkg::core_state_t state_reg;
   logic_op_pkg::core_state_t state_next;

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // No logic after the state flops, so the bus sees clean edges
   assign apb_rsp  = state_reg.rsp;
   assign core_evt = state_reg.evt;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      logic [31:0] m;
      m = 32'hffff_ffff;
      case (sz)
         logic_op_pkg::SZ_BYTE: begin
            m = 32'h0000_00ff;
         end
         logic_op_pkg::SZ_WORD: begin
            m = 32'h0000_ffff;
         end
         default: begin
            m = 32'hffff_ffff;
         end
      endcase
      return m;
   endfunction

   function automatic logic size_msb(input logic [31:0] v, input logic [1:0] sz);
      logic b;
      b = v[31];
      case (sz)
         logic_op_pkg::SZ_BYTE: begin
            b = v[7];
         end
         logic_op_pkg::SZ_WORD: begin
            b = v[15];
         end
         default: begin
            b = v[31];
         end
      endcase
      return b;
   endfunction

   // Data-alterable: no address register, extended only absolute forms
   function automatic logic data_alterable(input logic [2:0] md, input logic [2:0] rg);
      logic ok;
      ok = md != logic_op_pkg::MODE_ADDRESS_REG;
      if (md == logic_op_pkg::MODE_EXTENDED) begin
         // Program-relative and immediate forms cannot be written
         ok = rg <= logic_op_pkg::EXT_ABS_LONG;
      end
      return ok;
   endfunction

   // -------------------------------------------------------------
   // Decode of the held opcode
   // -------------------------------------------------------------
   logic [2:0]  ea_mode;
   logic [2:0]  ea_reg;
   logic [1:0]  op_size;
   logic        is_nop;
   logic        is_not;
   logic        is_negate_with_extend;
   logic        is_or;
   logic        or_to_ea;
   logic        size_ok;
   logic        dst_alt_ok;
   logic        src_data_ok;
   logic        mem_alt_ok;
   logic        legal;

   always_comb begin
      ea_mode  = state_reg.opcode[5:3];
      ea_reg   = state_reg.opcode[2:0];
      op_size  = state_reg.opcode[7:6];
      or_to_ea = state_reg.opcode[8];
      is_nop   = state_reg.opcode == logic_op_pkg::NO_OPERATION_WORD;
      is_not   = state_reg.opcode[15:8] == logic_op_pkg::COMPLEMENT_HI;
      is_negate_with_extend  = state_reg.opcode[15:8] == logic_op_pkg::NEGATE_WITH_EXTEND_HI;
      is_or    = state_reg.opcode[15:12] == logic_op_pkg::DISJUNCTION_TOP;
      // Legality terms
      size_ok     = op_size != 2'h3;
      dst_alt_ok  = data_alterable(ea_mode, ea_reg);
      // Any data mode as source, up to immediate
      src_data_ok = (ea_mode != logic_op_pkg::MODE_ADDRESS_REG) &&
                    ((ea_mode != logic_op_pkg::MODE_EXTENDED) ||
                     (ea_reg <= logic_op_pkg::EXT_IMMEDIATE));
      // Register targets must use the other direction
      mem_alt_ok  = (ea_mode != logic_op_pkg::MODE_DATA_REG) && dst_alt_ok;
      legal       = 1'b0;
      if (is_nop) begin
         legal = 1'b1;
      end else if (is_not || is_negate_with_extend) begin
         legal = size_ok && dst_alt_ok;
      end else if (is_or) begin
         if (!size_ok) begin
            legal = 1'b0;
         end else if (!or_to_ea) begin
            legal = src_data_ok;
         end else begin
            legal = mem_alt_ok;
         end
      end
   end

   // -------------------------------------------------------------
   // Datapath
   // -------------------------------------------------------------
   logic [31:0] mask;
   logic [31:0] val;
   logic [32:0] negate_with_extend_diff;
   logic [31:0] merged;
   logic        res_msb;
   logic        res_zero;
   logic        borrow;
   logic        ovf;

   always_comb begin
      mask      = size_mask(op_size);
      // Full width difference; the size mask picks the live part
      negate_with_extend_diff = 33'h0_0000_0000 - {1'b0, state_reg.dst & mask}
                  - {32'h0000_0000, state_reg.ccr[logic_op_pkg::CCR_X]};
      if (is_not) begin
         val = ~state_reg.dst;
      end else if (is_or) begin
         val = state_reg.src | state_reg.dst;
      end else begin
         val = negate_with_extend_diff[31:0];
      end
      // Upper bytes of a byte or word result keep the destination
      merged   = (state_reg.dst & ~mask) | (val & mask);
      // ---------------------------------------------------------
      // Condition flags
      // ---------------------------------------------------------
      res_msb  = size_msb(val, op_size);
      res_zero = (val & mask) == 32'h0000_0000;
      // Zero minus d minus x borrows unless both are zero
      borrow   = ((state_reg.dst & mask) != 32'h0000_0000) ||
                 state_reg.ccr[logic_op_pkg::CCR_X];
      // Only the most negative operand overflows, and its sign stays set
      ovf      = size_msb(state_reg.dst, op_size) && res_msb;
   end

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   logic setup;
   logic access;
   logic wr_ok;

   always_comb begin
      state_next                  = state_reg;
      state_next.rsp.pready       = 1'b0;
      state_next.rsp.pslverr      = 1'b0;
      state_next.evt.retire       = 1'b0;
      state_next.evt.illegal_trap = 1'b0;
      setup  = apb_req.psel && !apb_req.penable;
      access = apb_req.psel && apb_req.penable && state_reg.rsp.pready;
      wr_ok  = access && apb_req.pwrite && !state_reg.evt.busy;

      // -------------------------------------------------------------
      // Register read answer
      // -------------------------------------------------------------
      // Answer is prepared in setup, so the access phase takes no wait state
      if (setup) begin
         state_next.rsp.pready = 1'b1;
         state_next.rsp.prdata = 32'h0000_0000;
         case (apb_req.paddr)
            logic_op_pkg::OFF_OPCODE: begin
               state_next.rsp.prdata = {16'h0000, state_reg.opcode};
            end
            logic_op_pkg::OFF_SRC: begin
               state_next.rsp.prdata = state_reg.src;
            end
            logic_op_pkg::OFF_DST: begin
               state_next.rsp.prdata = state_reg.dst;
            end
            logic_op_pkg::OFF_CCR: begin
               state_next.rsp.prdata = {27'h000_0000, state_reg.ccr};
            end
            logic_op_pkg::OFF_RESULT: begin
               state_next.rsp.prdata = state_reg.result;
            end
            logic_op_pkg::OFF_STATUS: begin
               state_next.rsp.prdata[logic_op_pkg::ST_BUSY]    = state_reg.evt.busy;
               state_next.rsp.prdata[logic_op_pkg::ST_DONE]    = state_reg.done;
               state_next.rsp.prdata[logic_op_pkg::ST_ILLEGAL] = state_reg.illegal;
               state_next.rsp.prdata[logic_op_pkg::ST_WB]      = state_reg.wb;
            end
            default: begin
               state_next.rsp.pslverr = 1'b1;
            end
         endcase
      end

      // -------------------------------------------------------------
      // Register write
      // -------------------------------------------------------------
      // Operand writes are refused while an instruction is in flight;
      // they are dropped silently, so software must poll the busy bit
      if (wr_ok) begin
         case (apb_req.paddr)
            logic_op_pkg::OFF_OPCODE: begin
               state_next.opcode   = apb_req.pwdata[15:0];
               state_next.state    = logic_op_pkg::S_EXEC;
               state_next.evt.busy = 1'b1;
               state_next.done     = 1'b0;
               state_next.illegal  = 1'b0;
               state_next.wb       = 1'b0;
            end
            logic_op_pkg::OFF_SRC: begin
               state_next.src = apb_req.pwdata;
            end
            logic_op_pkg::OFF_DST: begin
               state_next.dst = apb_req.pwdata;
            end
            logic_op_pkg::OFF_CCR: begin
               state_next.ccr = apb_req.pwdata[4:0];
            end
            default: begin
               state_next.src = state_reg.src;
            end
         endcase
      end

      // -------------------------------------------------------------
      // Execution sequencer
      // -------------------------------------------------------------
      case (state_reg.state)
         logic_op_pkg::S_IDLE: begin
            // Busy follows an accepted opcode write
            state_next.evt.busy = state_next.state != logic_op_pkg::S_IDLE;
         end
         logic_op_pkg::S_EXEC: begin
            if (!legal) begin
               // Nothing but the trap and the illegal, done and busy status bits change
               state_next.illegal          = 1'b1;
               state_next.evt.illegal_trap = 1'b1;
               state_next.done             = 1'b1;
               state_next.evt.busy         = 1'b0;
               state_next.state            = logic_op_pkg::S_IDLE;
            end else if (is_nop) begin
               // Flags and result stay as they are
               state_next.state = logic_op_pkg::S_DRAIN;
            end else begin
               state_next.result = merged;
               state_next.wb     = 1'b1;
               state_next.ccr[logic_op_pkg::CCR_N] = res_msb;
               if (is_negate_with_extend) begin
                  // Z only ever cleared, so multi-word chains test as a whole
                  state_next.ccr[logic_op_pkg::CCR_Z] =
                     res_zero && state_reg.ccr[logic_op_pkg::CCR_Z];
                  state_next.ccr[logic_op_pkg::CCR_V] = ovf;
                  state_next.ccr[logic_op_pkg::CCR_C] = borrow;
                  state_next.ccr[logic_op_pkg::CCR_X] = borrow;
               end else begin
                  state_next.ccr[logic_op_pkg::CCR_Z] = res_zero;
                  state_next.ccr[logic_op_pkg::CCR_V] = 1'b0;
                  state_next.ccr[logic_op_pkg::CCR_C] = 1'b0;
               end
               state_next.done       = 1'b1;
               state_next.evt.retire = 1'b1;
               state_next.evt.busy   = 1'b0;
               state_next.state      = logic_op_pkg::S_IDLE;
            end
         end
         logic_op_pkg::S_DRAIN: begin
            // Holding here stops any later instruction from overlapping
            if (!bus_pending) begin
               state_next.done       = 1'b1;
               state_next.evt.retire = 1'b1;
               state_next.evt.busy   = 1'b0;
               state_next.state      = logic_op_pkg::S_IDLE;
            end
         end
         default: begin
            state_next.state    = logic_op_pkg::S_IDLE;
            state_next.evt.busy = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.state            <= logic_op_pkg::S_IDLE;
         state_reg.opcode           <= logic_op_pkg::OPCODE_RST;
         state_reg.src              <= logic_op_pkg::DATA_RST;
         state_reg.dst              <= logic_op_pkg::DATA_RST;
         state_reg.ccr              <= logic_op_pkg::CCR_RST;
         state_reg.result           <= logic_op_pkg::DATA_RST;
         state_reg.done             <= 1'b0;
         state_reg.illegal          <= 1'b0;
         state_reg.wb               <= 1'b0;
         state_reg.rsp.prdata       <= logic_op_pkg::DATA_RST;
         state_reg.rsp.pready       <= 1'b0;
         state_reg.rsp.pslverr      <= 1'b0;
         state_reg.evt.busy         <= 1'b0;
         state_reg.evt.retire       <= 1'b0;
         state_reg.evt.illegal_trap <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

/* File: rtl/logic_op_pkg.sv */
package logic_op_pkg;

   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [11:0] OFF_OPCODE = 12'h000;
   localparam logic [11:0] OFF_SRC    = 12'h004;
   localparam logic [11:0] OFF_DST    = 12'h008;
   localparam logic [11:0] OFF_CCR    = 12'h00c;
   localparam logic [11:0] OFF_RESULT = 12'h010;
   localparam logic [11:0] OFF_STATUS = 12'h014;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CCR_C = 0;
   localparam int CCR_V = 1;
   localparam int CCR_Z = 2;
   localparam int CCR_N = 3;
   localparam int CCR_X = 4;

   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_ILLEGAL = 2;
   localparam int ST_WB      = 3;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [15:0] OPCODE_RST = 16'h0000;
   localparam logic [31:0] DATA_RST   = 32'h0000_0000;
   localparam logic [4:0]  CCR_RST    = 5'h00;

   // -------------------------------------------------------------
   // Opcode encodings
   // -------------------------------------------------------------
   localparam logic [15:0] NO_OPERATION_WORD = 16'h4e71;
   localparam logic [7:0]  COMPLEMENT_HI     = 8'h46;
   localparam logic [7:0]  NEGATE_WITH_EXTEND_HI = 8'h40;
   localparam logic [3:0]  DISJUNCTION_TOP   = 4'h8;

   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;

   localparam logic [2:0] MODE_DATA_REG    = 3'h0;
   localparam logic [2:0] MODE_ADDRESS_REG = 3'h1;
   localparam logic [2:0] MODE_EXTENDED    = 3'h7;
   localparam logic [2:0] EXT_ABS_LONG     = 3'h1;
   localparam logic [2:0] EXT_IMMEDIATE    = 3'h4;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_EXEC  = 2'b01,
      S_DRAIN = 2'b10
   } exec_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic busy;
      logic retire;
      logic illegal_trap;
   } core_evt_t;

   typedef struct packed {
      exec_state_t state;
      logic [15:0] opcode;
      logic [31:0] src;
      logic [31:0] dst;
      logic [4:0]  ccr;
      logic [31:0] result;
      logic        done;
      logic        illegal;
      logic        wb;
      apb_rsp_t    rsp;
      core_evt_t   evt;
   } core_state_t;

endpackage

/* File: bench/logic_op_decode_flags_sva.sv */
`timescale 1ns/1ps
module logic_op_chk (
   // Clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // Watched ports
   input wire logic_op_pkg::apb_req_t  apb_req,
   input wire logic_op_pkg::apb_rsp_t  apb_rsp,
   input wire logic                    bus_pending,
   input wire logic_op_pkg::core_evt_t core_evt
);
   logic [15:0] op_reg;
   logic        op_wr;
   logic        no_operation;
   logic [2:0]  md;
   logic [2:0]  rg;
   // ------------------------------------------------------------
   // Opcode tracking
   // ------------------------------------------------------------
   // Writes while busy are dropped, so only an idle write is captured
   assign op_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                  && apb_req.paddr == logic_op_pkg::OFF_OPCODE && !core_evt.busy;
   assign no_operation = op_reg == logic_op_pkg::NO_OPERATION_WORD;
   assign md = op_reg[5:3];
   assign rg = op_reg[2:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) op_reg <= 16'h0000;
      else if (op_wr) op_reg <= apb_req.pwdata[15:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   chk_ready_pulse: assert property (apb_req.psel && !apb_req.penable
      |=> apb_rsp.pready ##1 !apb_rsp.pready) else $error("pready not a single pulse");
   chk_write_starts: assert property (op_wr |=> core_evt.busy)
      else $error("opcode write did not start execution");
   chk_nop_waits: assert property (
      core_evt.busy && no_operation && bus_pending |=> core_evt.busy && !core_evt.retire)
      else $error("no-operation retired with bus cycles pending");
   chk_nop_legal: assert property (
      core_evt.busy && no_operation |=> !core_evt.illegal_trap) else $error("no-operation trapped");
   chk_exec_time: assert property (
      core_evt.busy && !no_operation |=> !core_evt.busy && (core_evt.retire ^ core_evt.illegal_trap))
      else $error("execution not one cycle");
   chk_size_bad: assert property (
      core_evt.busy && op_reg[15:8] == 8'h46 && op_reg[7:6] == 2'h3 |=> core_evt.illegal_trap)
      else $error("size 11 accepted");
   chk_alt_modes: assert property (
      core_evt.busy && (op_reg[15:8] == 8'h46 || op_reg[15:8] == 8'h40) && op_reg[7:6] != 2'h3
      |=> core_evt.illegal_trap == (md == 3'h1 || (md == 3'h7 && rg > 3'h1)))
      else $error("data-alterable check wrong");
   chk_or_opmode: assert property (
      core_evt.busy && op_reg[15:12] == 4'h8 && op_reg[7:6] == 2'h3 |=> core_evt.illegal_trap)
      else $error("reserved direction code accepted");
   chk_or_source: assert property (
      core_evt.busy && op_reg[15:12] == 4'h8 && !op_reg[8] && op_reg[7:6] != 2'h3
      |=> core_evt.illegal_trap == (md == 3'h1 || (md == 3'h7 && rg > 3'h4)))
      else $error("source mode check wrong");
   chk_or_dest: assert property (
      core_evt.busy && op_reg[15:12] == 4'h8 && op_reg[8] && op_reg[7:6] != 2'h3
      |=> core_evt.illegal_trap == (md < 3'h2 || (md == 3'h7 && rg > 3'h1)))
      else $error("destination mode check wrong");
endmodule

/* File: bench/logic_op_decode_flags_tb_top.sv */
`timescale 1ns/1ps
module logic_op_decode_flags_tb_top;
   logic                     pclk;
   logic                     presetn;
   logic_op_pkg::apb_req_t   req;
   logic_op_pkg::apb_rsp_t   rsp;
   logic                     bus_pending;
   logic_op_pkg::core_evt_t  evt;
   int                       err_count;
   int                       checked;
   int                       cyc;
   int                       seed;
   int                       i;
   logic [32:0]              expq[$];
   logic [32:0]              e_m;
   logic [31:0]              res_q;
   logic [15:0]              o;
   logic [15:0]              ops[21] = '{16'h4600, 16'h4641, 16'h4692, 16'h46f0, 16'h4608,
      16'h463c, 16'h4639, 16'h8010, 16'h807c, 16'h80ba, 16'h8008, 16'h8310, 16'h8550,
      16'h8790, 16'h80c0, 16'h81c0, 16'h8300, 16'h833c, 16'h833a, 16'h4068, 16'hffff};

   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   logic_op_decode_flags i_logic_op_decode_flags (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .bus_pending(bus_pending), .core_evt(evt));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("mismatches=%0d comparisons=%0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Register bus master
   // ------------------------------------------------------------
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // Only the bench timeout may end this wait
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp, input logic er = 1'b0);
      expq.push_back({er, exp});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Read results are compared where they appear, against the oldest note
   always @(posedge pclk) begin
      if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
         e_m = expq.pop_front();
         check({31'h0, rsp.pslverr}, {31'h0, e_m[32]});
         check(rsp.prdata, e_m[31:0]);
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   task wait_done;
      @(posedge pclk);
      while (evt.busy === 1'b1) begin
         @(posedge pclk);
      end
   endtask

   // ------------------------------------------------------------
   // One instruction, with its expected outcome
   // ------------------------------------------------------------
   task run(input logic [15:0] op, input logic [31:0] s, input logic [31:0] d,
            input logic [4:0] c);
      logic [31:0] m;
      logic [31:0] v;
      logic [31:0] r;
      logic [4:0]  ec;
      logic [3:0]  st;
      logic        bad;
      logic        neg;
      logic        nx;
      m = op[7:6] == 2'h0 ? 32'h0000_00ff : op[7:6] == 2'h1 ? 32'h0000_ffff : 32'hffff_ffff;
      bad = op[7:6] == 2'h3 || op[5:3] == 3'h1;
      nx = op[15:8] == 8'h40;
      ec = c;
      v = 32'h0;
      // Pending bus cycles must not matter outside the no-operation case
      bus_pending <= 1'($random(seed));
      if (op[15:8] == 8'h46 || nx) begin
         bad = bad || (op[5:3] == 3'h7 && op[2:0] > 3'h1);
         v = nx ? 32'h0 - d - c[4] : ~d;
      end else if (op[15:12] == 4'h8) begin
         if (op[8]) bad = bad || op[5:3] == 3'h0 || (op[5:3] == 3'h7 && op[2:0] > 3'h1);
         else bad = bad || (op[5:3] == 3'h7 && op[2:0] > 3'h4);
         v = s | d;
      end else bad = 1'b1;
      r = (d & ~m) | (v & m);
      neg = |(r & m & ~(m >> 1));
      st = bad ? 4'h6 : 4'ha;
      if (!bad) begin
         res_q = r;
         ec[3] = neg;
         ec[2] = (r & m) == 32'h0;
         ec[1:0] = 2'h0;
         if (nx) begin
            ec[2] = (r & m) == 32'h0 ? c[2] : 1'b0;
            ec[0] = (d & m) != 32'h0 || c[4];
            ec[1] = neg && |(d & m & ~(m >> 1));
            ec[4] = ec[0];
         end
      end
      apb(1'b1, logic_op_pkg::OFF_SRC, s);
      apb(1'b1, logic_op_pkg::OFF_DST, d);
      apb(1'b1, logic_op_pkg::OFF_CCR, {27'h0, c});
      apb(1'b1, logic_op_pkg::OFF_OPCODE, {16'h0, op});
      wait_done();
      rd(logic_op_pkg::OFF_RESULT, res_q);
      rd(logic_op_pkg::OFF_CCR, {27'h0, ec});
      rd(logic_op_pkg::OFF_STATUS, {28'h0, st});
   endtask

   initial begin
      seed = 82;
      req = '0;
      bus_pending = 1'b0;
      presetn = 1'b0;
      res_q = 32'h0;
      err_count = 0;
      checked = 0;
      cyc = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then one unmapped word
      for (i = 0; i < 7; i++) rd(12'(i * 4), 32'h0, i == 6);
      foreach (ops[k]) run(ops[k], $random(seed), $random(seed), 5'($random(seed)));
      // Most negative byte operand, without and with extend
      run(16'h4000, 32'h0, 32'h1234_5680, 5'h00);
      run(16'h4000, 32'h0, 32'h1234_5680, 5'h14);
      for (i = 0; i < 40; i++) begin
         o = 16'($random(seed));
         if (i % 3 == 0) o[15:12] = 4'h8;
         else o[15:8] = i % 3 == 1 ? 8'h46 : 8'h40;
         run(o, $random(seed), $random(seed), 5'($random(seed)));
      end
      // No-operation held by pending bus cycles; a flag write meanwhile is dropped
      bus_pending <= 1'b1;
      apb(1'b1, logic_op_pkg::OFF_CCR, 32'h0000_0015);
      apb(1'b1, logic_op_pkg::OFF_OPCODE, {16'h0, logic_op_pkg::NO_OPERATION_WORD});
      repeat (4) @(posedge pclk);
      check({31'h0, evt.busy}, 32'h1);
      apb(1'b1, logic_op_pkg::OFF_CCR, 32'h0000_0000);
      bus_pending <= 1'b0;
      wait_done();
      rd(logic_op_pkg::OFF_CCR, 32'h0000_0015);
      rd(logic_op_pkg::OFF_RESULT, res_q);
      rd(logic_op_pkg::OFF_STATUS, 32'h0000_0002);
      apb(1'b1, logic_op_pkg::OFF_RESULT, 32'hffff_ffff);
      rd(logic_op_pkg::OFF_RESULT, res_q);
      close_out();
   end
endmodule

bind logic_op_decode_flags logic_op_chk i_logic_op_chk (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .bus_pending(bus_pending), .core_evt(core_evt));
